// file: rtl/char_video_pkg.sv
/*
  Shared constants for the character-cell video path: dot counter
  reload, cell geometry, sweep timing and bus widths.
  Assumes a 100 MHz system clock; all timing counts derive from it.
*/
package char_video_pkg;
  // System clock period
  localparam int CLK_PERIOD_NS = 10;
  // Sweep period and horizontal sync width, as times
  localparam int SWEEP_NS = 58500;
  localparam int SYNC_NS = 4500;
  // Sync width in clock cycles, rounded down
  localparam int SYNC_CYC = SYNC_NS / CLK_PERIOD_NS;
  // Dot counter: 4 bits, reloads 6 on carry, so 10 dots per cell
  localparam logic [3:0] DOT_RELOAD = 4'h6;
  localparam logic [3:0] DOT_CARRY = 4'hF;
  // Last count of the dot clock enable divider: four system clocks per dot
  localparam logic [1:0] DOT_DIV_LAST = 2'h3;
  // Last sweep of a text row (fifteen sweeps per row), and sweeps per graphic sub-row
  localparam logic [3:0] ROW_LAST_SWEEP = 4'hE;
  localparam logic [3:0] SUB_SWEEPS = 4'h5;
  // Character cells per text row
  localparam logic [9:0] ROW_COLS = 10'h040;
  // Widths
  localparam int ADDR_W = 10;
  localparam int CODE_W = 8;
  localparam int PAT_W = 9;
  // Graphics sub-row codes
  localparam logic [1:0] SUB_TOP = 2'h0;
  localparam logic [1:0] SUB_MID = 2'h1;
  localparam logic [1:0] SUB_BOT = 2'h2;
endpackage

// file: rtl/dot_counter.sv
/*
  Dot counter: 4-bit binary counter advanced on each dot enable,
  reloading 6 on carry so that it carries once every ten dots.
  Assumes tickEn is a one-cycle enable already gated by blanking.
*/
`timescale 1ns/100ps
module dot_counter
  import char_video_pkg::*;
(
  input wire logic sysClk, // System clock
  input wire logic rstSyncN, // Synchronised reset, active low
  input wire logic tickEn, // One dot
  output logic [3:0] dotCount, // Current count
  output logic eoc // End of character, one cycle
);
  // Count register
  logic [3:0] cnt_q;

  // Advance, reload 6 on carry
  always_ff @(posedge sysClk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      cnt_q <= DOT_RELOAD;
    else if (tickEn)
    begin
      if (cnt_q == DOT_CARRY)
        cnt_q <= DOT_RELOAD;
      else
        cnt_q <= cnt_q + 4'h1;
    end
  end

  assign dotCount = cnt_q;
  // Carry qualified by the dot: the tenth-dot pulse
  assign eoc = tickEn && (cnt_q == DOT_CARRY);
endmodule // dot_counter

// file: rtl/dot_serializer.sv
/*
  Dot serializer: parallel-load shift register, MSB first, shifting a
  dark level in behind the pattern. Load and shift are active low.
  Assumes loadN falls only in a cycle where shiftN is also low.
*/
`timescale 1ns/100ps
module dot_serializer
  import char_video_pkg::*;
(
  input wire logic sysClk, // System clock
  input wire logic rstSyncN, // Synchronised reset, active low
  input wire logic loadN, // Parallel load, active low
  input wire logic shiftN, // Dot shift, active low
  input wire logic [PAT_W-1:0] parDots, // Dot pattern
  output logic dotOut // Serial video dot
);
  // Pattern plus the dark tenth position
  logic [PAT_W:0] sr_q;

  // Load wins over shift; dark shifts
  always_ff @(posedge sysClk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      sr_q <= '0;
    else if (!loadN)
      sr_q <= {parDots, 1'b0};
    else if (!shiftN)
      sr_q <= {sr_q[PAT_W-1:0], 1'b0};
  end

  // Top stage drives the video
  assign dotOut = sr_q[PAT_W];
endmodule // dot_serializer

// file: rtl/character_video_serializer.sv
/*
  Character-cell video path: dot enable, blanking gate, dot counter,
  character code latch, address and sweep counters, block graphics,
  generator mux and dot serializer; horizontal sync from sys_clk.
  Assumes the display memory and character ROM answer combinationally
  and that hBlank is synchronous to sys_clk.
*/
`timescale 1ns/100ps
module character_video_serializer
  import char_video_pkg::*;
#(
  parameter int SWEEP_CYC = SWEEP_NS / CLK_PERIOD_NS // Sweep period in cycles
)
(
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic hBlank, // Horizontal blanking, active high
  input wire logic forceGfxN, // Force graphics select, active low
  input wire logic [CODE_W-1:0] memData, // Internal data bus
  input wire logic [PAT_W-1:0] romDots, // Character ROM dots
  output logic [ADDR_W-1:0] memAddr, // Display memory address
  output logic [CODE_W-1:0] charCode, // Latched code to generators
  output logic [3:0] sweepInRow, // Sweep within the text row
  output logic hSync, // Horizontal sync, active high
  output logic eocPulse, // End of character, one cycle
  output logic videoDot // Serial dot video
);
  // Reset synchroniser stages
  logic rstMeta_q;
  logic rstSyncN;
  // Sweep divider
  logic [12:0] hCnt_q;
  logic sweepEnd;
  logic hSync_q;
  // Dot enable divider
  logic [1:0] dotDiv_q;
  logic dotTick;
  // Dot counter
  logic [3:0] dotCount;
  logic eoc;
  logic eocN;
  logic shiftN;
  // Character latch and addressing
  logic [CODE_W-1:0] code_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] rowBase_q;
  logic [3:0] sweep_q;
  logic [1:0] subRow_q;
  logic [3:0] subCnt_q;
  // Generators
  logic [PAT_W-1:0] gfxDots;
  logic [PAT_W-1:0] dotPattern;
  logic muxSel;
  logic gfxLeft;
  logic gfxRight;

  // Reset release through two flops; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSyncN <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSyncN <= rstMeta_q;
    end
  end

  // Sweep divider straight off sys_clk, not the dot clock
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      hCnt_q <= '0;
    else if (sweepEnd)
      hCnt_q <= '0;
    else
      hCnt_q <= hCnt_q + 13'h0001;
  end

  assign sweepEnd = (hCnt_q == 13'(SWEEP_CYC - 1));

  // Sync pulse at the head of each sweep
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      hSync_q <= 1'b0;
    else if (sweepEnd)
      hSync_q <= 1'b1;
    else if (hCnt_q == 13'(SYNC_CYC - 1))
      hSync_q <= 1'b0;
  end

  // Dot enable divider; stands in for the separate dot oscillator
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      dotDiv_q <= '0;
    else if (dotDiv_q == DOT_DIV_LAST)
      dotDiv_q <= '0;
    else
      dotDiv_q <= dotDiv_q + 2'h1;
  end

  // Blanking kills the dot clock, so no dots and no pulses
  assign dotTick = (dotDiv_q == DOT_DIV_LAST) && !hBlank;
  // Active-low copies toward the serializer
  assign shiftN = !dotTick;
  assign eocN = !eoc;

  // Ten-dot character divider
  dot_counter u_dotCounter (
    .sysClk(sys_clk),
    .rstSyncN(rstSyncN),
    .tickEn(dotTick),
    .dotCount(dotCount),
    .eoc(eoc)
  );

  // Code latch: invert top bit, keep the rest by weight
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      code_q <= '0;
    else if (!eocN)
      code_q <= {!memData[CODE_W-1], memData[CODE_W-2:0]};
  end

  // Sweep within the row, wrapping after fifteen
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      sweep_q <= '0;
    else if (sweepEnd)
    begin
      if (sweep_q == ROW_LAST_SWEEP)
        sweep_q <= '0;
      else
        sweep_q <= sweep_q + 4'h1;
    end
  end

  // Graphic sub-row every five sweeps
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      subCnt_q <= '0;
      subRow_q <= SUB_TOP;
    end
    else if (sweepEnd)
    begin
      if (sweep_q == ROW_LAST_SWEEP)
      begin
        subCnt_q <= '0;
        subRow_q <= SUB_TOP;
      end
      else if (subCnt_q == SUB_SWEEPS - 4'h1)
      begin
        subCnt_q <= '0;
        subRow_q <= subRow_q + 2'h1;
      end
      else
        subCnt_q <= subCnt_q + 4'h1;
    end
  end

  // Row base steps one row after the last sweep; memory just wraps
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      rowBase_q <= '0;
    else if (sweepEnd && sweep_q == ROW_LAST_SWEEP)
      rowBase_q <= rowBase_q + ROW_COLS;
  end

  // Address: restarts each sweep, steps per character, no host
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      addr_q <= '0;
    else if (sweepEnd)
    begin
      // Same row repeats its codes on every sweep
      if (sweep_q == ROW_LAST_SWEEP)
        addr_q <= rowBase_q + ROW_COLS;
      else
        addr_q <= rowBase_q;
    end
    else if (eoc)
      addr_q <= addr_q + 10'h001;
  end

  // Block graphics: two blocks per sub-row from code bits
  always_comb
  begin
    gfxLeft = 1'b0;
    gfxRight = 1'b0;
    unique case (subRow_q)
      SUB_TOP:
      begin
        gfxLeft = code_q[0];
        gfxRight = code_q[1];
      end
      SUB_MID:
      begin
        gfxLeft = code_q[2];
        gfxRight = code_q[3];
      end
      SUB_BOT:
      begin
        gfxLeft = code_q[4];
        gfxRight = code_q[5];
      end
      // Code 3 never reached; shows dark
      default:
      begin
        gfxLeft = 1'b0;
        gfxRight = 1'b0;
      end
    endcase
  end

  // Five dots left block, four right; tenth stays dark
  assign gfxDots = {{5{gfxLeft}}, {4{gfxRight}}};
  // Low select picks graphics; forceGfxN low forces it
  assign muxSel = code_q[CODE_W-1] && forceGfxN;
  assign dotPattern = muxSel ? romDots : gfxDots;

  // Dot serializer, loaded by the inverted pulse
  dot_serializer u_dotSerializer (
    .sysClk(sys_clk),
    .rstSyncN(rstSyncN),
    .loadN(eocN),
    .shiftN(shiftN),
    .parDots(dotPattern),
    .dotOut(videoDot)
  );

  // Outputs
  assign memAddr = addr_q;
  assign charCode = code_q;
  assign sweepInRow = sweep_q;
  assign hSync = hSync_q;
  assign eocPulse = eoc;

  // Helper: dots since the last end-of-character
  logic [3:0] dotsSince_q;
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      dotsSince_q <= '0;
    else if (eoc)
      dotsSince_q <= '0;
    else if (dotTick)
      dotsSince_q <= dotsSince_q + 4'h1;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstSyncN);

  // Row wrap seen on the sweep counter
  sequence lastSweepEnd;
    sweepEnd && sweep_q == ROW_LAST_SWEEP;
  endsequence
  sequence rowRestarted;
    ##1 sweep_q == 4'h0 && subRow_q == SUB_TOP;
  endsequence

  chk_eoc_spacing: assert property (eoc |-> dotsSince_q == 4'h9)
    else $error("end of character not on tenth dot");
  chk_count_range: assert property (dotCount >= DOT_RELOAD)
    else $error("dot counter below its reload value");
  chk_column_step: assert property (eoc && !sweepEnd |=> memAddr == $past(memAddr) + 10'h001)
    else $error("column did not advance on end of character");
  chk_load_dot: assert property (eoc |=> videoDot == $past(dotPattern[PAT_W-1]))
    else $error("serializer did not load pattern MSB");
  chk_dot_hold: assert property (!dotTick |=> $stable(videoDot))
    else $error("dot moved without dot clock");
  chk_blank_gate: assert property (hBlank |-> !dotTick && !eoc)
    else $error("dot activity during blanking");
  chk_row_height: assert property (lastSweepEnd |-> rowRestarted)
    else $error("row did not wrap after fifteen sweeps");
  chk_code_hold: assert property (!eoc |=> $stable(charCode))
    else $error("character code changed between pulses");
  chk_sub_row: assert property (sweepEnd && sweep_q == 4'h4 |=> subRow_q == SUB_MID)
    else $error("graphics sub-row not at fifth sweep");
  chk_latch_data: assert property (eoc |=> charCode[6:0] == $past(memData[6:0]))
    else $error("latched code differs from data bus");
  chk_msb_invert: assert property (eoc |=> charCode[7] == !$past(memData[7]))
    else $error("top code bit not inverted");
  chk_gfx_force: assert property (!forceGfxN |-> dotPattern == gfxDots)
    else $error("forced select did not pick graphics");
  chk_sync_start: assert property (sweepEnd |=> hSync ##1 hSync)
    else $error("sync did not start at sweep end");
  chk_sync_end: assert property ($fell(hSync) |-> hCnt_q == 13'(SYNC_CYC))
    else $error("sync width wrong");
  chk_dark_tail: assert property (dotsSince_q == 4'h9 |-> !videoDot)
    else $error("tenth dot not dark");
endmodule // character_video_serializer

// file: verif/video_monitor.sv
/*
  Video monitor model: measures sync pulse width and sync period.
  Assumes hSync and videoDot come from the serializer on sysClk.
*/
`timescale 1ns/100ps
module video_monitor
(
  input wire logic sysClk, // System clock
  input wire logic hSync, // Horizontal sync
  input wire logic videoDot, // Serial dot, only received
  output int syncWidth, // Last sync width, cycles
  output int syncPeriod // Last rise-to-rise spacing
);
  int highCnt = 0; // Cycles high so far
  int perCnt = 0; // Cycles since last rise
  logic syncPrev = 1'b0; // Sync one cycle ago
  // A monitor locks on rise spacing, so both figures matter
  always @(posedge sysClk)
  begin
    syncPrev <= hSync;
    perCnt <= perCnt + 1;
    // Rising edge ends one period
    if (hSync && !syncPrev)
    begin
      syncPeriod <= perCnt;
      perCnt <= 1;
    end
    // Falling edge ends one pulse
    if (hSync)
      highCnt <= highCnt + 1;
    else if (syncPrev)
    begin
      syncWidth <= highCnt;
      highCnt <= 0;
    end
  end
endmodule // video_monitor

// file: verif/test_character_video_serializer.sv
/*
  Bench for the character video path: memory data, ROM dots, blanking
  and graphics force; checks dots, latch, address and sync.
  Assumes a shortened 600-cycle sweep.
*/
`timescale 1ns/100ps
module test_character_video_serializer
  import char_video_pkg::*;
;
  localparam int SWEEP = 600; // Shortened sweep, still above sync
  logic sys_clk = 1'b0; // System clock
  logic rst_n = 1'b0; // Reset, active low
  logic hBlank = 1'b0; // Blanking
  logic forceGfxN = 1'b1; // Graphics force, active low
  logic [CODE_W-1:0] memData = 8'h00; // Memory data
  logic [PAT_W-1:0] romDots = 9'h000; // ROM pattern
  logic [ADDR_W-1:0] memAddr; // Memory address
  logic [CODE_W-1:0] charCode; // Latched code
  logic [3:0] sweepInRow; // Sweep in row
  logic hSync; // Sync
  logic eocPulse; // End of character
  logic videoDot; // Serial dot
  int syncWidth; // Measured sync width
  int syncPeriod; // Measured period
  int err_count = 0; // Mismatches
  int total_checks = 0; // Comparisons
  logic [7:0] rnd = 8'h23; // Random state, seed 35
  logic [7:0] code; // Code under test
  logic [ADDR_W-1:0] base; // Row base
  logic [3:0] swp; // Sweep index
  int n; // Scratch count

  // 10 ns clock
  always #5 sys_clk = ~sys_clk;

  character_video_serializer #(.SWEEP_CYC(SWEEP)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .hBlank(hBlank), .forceGfxN(forceGfxN), .memData(memData), .romDots(romDots),
    .memAddr(memAddr), .charCode(charCode), .sweepInRow(sweepInRow), .hSync(hSync),
    .eocPulse(eocPulse), .videoDot(videoDot));

  video_monitor mon (.sysClk(sys_clk), .hSync(hSync), .videoDot(videoDot),
    .syncWidth(syncWidth), .syncPeriod(syncPeriod));

  // Eight-bit shift register for repeatable stimulus
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Wait for a pulse, bounded; gap counts negedges waited
  task automatic wait_eoc(output int gap);
    gap = 0;
    do
    begin
      @(negedge sys_clk);
      gap++;
    end
    while (eocPulse !== 1'b1 && gap < 200);
  endtask

  // Wait for a sync rise, bounded by one sweep and more
  task automatic wait_rise();
    logic prev;
    prev = hSync;
    @(negedge sys_clk);
    for (int i = 0; i < 1000 && !(hSync === 1'b1 && prev === 1'b0); i++)
    begin
      prev = hSync;
      @(negedge sys_clk);
    end
  endtask

  // Graphics dots by rule: sub-row from sweep, left five, right four
  function automatic logic [8:0] gfx_pat(input logic [7:0] c, input logic [3:0] sw);
    logic [1:0] b;
    b = (sw < 4'h5) ? c[1:0] : ((sw < 4'hA) ? c[3:2] : c[5:4]);
    return {{5{b[0]}}, {4{b[1]}}};
  endfunction

  // Latch one code, then watch its ten dots leave the serializer
  task automatic char_cell(input logic [7:0] c, input logic g, input logic [8:0] pat);
    int gap;
    logic [ADDR_W-1:0] a;
    logic [3:0] s;
    logic [8:0] exp;
    @(posedge sys_clk);
    #1;
    memData = c;
    forceGfxN = g;
    romDots = pat;
    wait_eoc(gap);
    a = memAddr;
    s = sweepInRow;
    @(negedge sys_clk);
    check(charCode, {~c[7], c[6:0]});
    if (sweepInRow === s)
      check(memAddr, a + 10'h001);
    wait_eoc(gap);
    check(gap, 39);
    // Stored top bit set or force low picks graphics; sub-row at load
    exp = (c[7] || !g) ? gfx_pat(c, sweepInRow) : pat;
    for (int k = 0; k < 10; k++)
    begin
      @(negedge sys_clk);
      check(videoDot, (k < 9) ? exp[8 - k] : 1'b0);
      repeat (3) @(negedge sys_clk);
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    // Random codes: ROM or graphics by stored top bit and force
    repeat (8)
    begin
      rnd = lfsr(rnd);
      code = rnd;
      rnd = lfsr(rnd);
      char_cell(code, rnd[7], {rnd, code[0]});
    end
    // Graphics by stored top bit, and by force
    char_cell(8'hBF, 1'b1, 9'h000);
    char_cell(8'h3F, 1'b0, 9'h000);
    char_cell(8'hC0, 1'b1, 9'h1FF);
    char_cell(8'h40, 1'b0, 9'h1FF);
    // One mixed-bit graphics code in each sub-row
    repeat (3)
    begin
      repeat (5) wait_rise();
      char_cell(8'hB9, 1'b1, 9'h000);
    end
    // Blank just after a bright load: no pulse, no shift
    char_cell(8'h00, 1'b1, 9'h1FF);
    wait_eoc(n);
    @(posedge sys_clk);
    #1;
    hBlank = 1'b1;
    n = 0;
    repeat (200)
    begin
      @(negedge sys_clk);
      n += (eocPulse !== 1'b0);
    end
    check(n, 0);
    check(videoDot, 1'b1);
    @(posedge sys_clk);
    #1;
    hBlank = 1'b0;
    // Fifteen sweeps move the row base by one row, unaided
    wait_rise();
    base = memAddr;
    swp = sweepInRow;
    repeat (15)
    begin
      wait_rise();
      check(sweepInRow < 4'hF, 1'b1);
    end
    check(sweepInRow, swp);
    check(memAddr, base + ROW_COLS);
    check(syncWidth, SYNC_CYC);
    check(syncPeriod, SWEEP);
    test_done();
  end

  // Watchdog, about two and a half times the expected run
  initial
  begin
    #500000;
    err_count++;
    test_done();
  end
endmodule // test_character_video_serializer
